// ### shared/ddrpi_pkg.sv
// Constants and types for the DDR2 pin-side device model.
// Assumes a single core clock that oversamples every memory pin.
package ddrpi_pkg;
  localparam int ROW_W      = 12;
  localparam int ADDR_W     = 13;
  localparam int BA_W       = 2;
  localparam int BANKS      = 4;
  localparam int DQ_W       = 16;
  localparam int LANE_W     = 8;
  localparam int LANES      = 2;
  localparam int MEM_AW     = 8;
  localparam int MEM_WORDS  = 256;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 4;
  // Mode word fields and the auto-precharge address bit
  localparam int FLD_W      = 3;
  localparam int BL_LSB     = 0;
  localparam int AL_LSB     = 3;
  localparam int CL_LSB     = 4;
  localparam int AP_BIT     = 10;
  localparam int DQSN_BIT   = 10;
  // Burst wrap and storage index fields
  localparam int WRAP8_W    = 3;
  localparam int WRAP4_W    = 2;
  localparam int ROWSEL_W   = 2;
  localparam int COLSEL_W   = 4;
  localparam logic [FLD_W-1:0] BL_CODE4 = 3'h2;
  localparam logic [FLD_W-1:0] BL_CODE8 = 3'h3;
  localparam logic [CNT_W-1:0] BL4      = 4'h4;
  localparam logic [CNT_W-1:0] BL8      = 4'h8;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [FLD_W-1:0] CL_RST   = 3'h3;
  localparam logic [FLD_W-1:0] AL_RST   = 3'h0;
  localparam logic [BA_W-1:0]  BA_MR    = 2'h0;
  localparam logic [BA_W-1:0]  BA_EMR1  = 2'h1;

  // Row strobe, column strobe, write enable (all active low)
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR  = 3'b100,
    CMD_RD  = 3'b101,
    CMD_RSV = 3'b110,
    CMD_NOP = 3'b111
  } ddrpi_cmd_t;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_WAIT  = 2'b01,
    PH_BURST = 2'b10
  } ddrpi_phase_t;

  typedef struct packed {
    logic              csN;
    logic              rasN;
    logic              casN;
    logic              weN;
    logic              cke;
    logic              odt;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } ddrpi_ctl_t;

  typedef struct packed {
    logic [MEM_AW-1:0] addr;
    logic [LANE_W-1:0] data;
  } ddrpi_beat_t;
endpackage

// ### hdl/ddrpi_device.sv
// DDR2 device pin behaviour: command decode, bank state, read and write bursts.
// Assumes every pin is asynchronous to core_clk and at least 8x slower.
// Behaviour
// R1 - Activate latches row into selected bank
// R2 - Column A0-A8 picks location in row; storage uses A0-A3 only
// R3 - A10 on read/write requests auto-precharge
// R4 - A12 only for mode register loads
// R5 - Bank inputs select the commanded bank
// R6 - Registered ODT high turns termination on
// R7 - Read strobe edge-aligned; write strobe centred
// R8 - Each byte strobe times its own lane
// R9 - Complementary strobe only in differential mode
// R10 - Chip select high masks every command
// R11 - Command from strobes and select together
// R12 - Masked write beats are not stored
// R13 - Inputs sampled on rising clock crossing
// R14 - Read beats launched on both crossings
// R15 - Clock enable low stops internal clocking
// R16 - Bursts of exactly four or eight beats
// R17 - RL equals AL plus CL; WL=RL-1
// R18 - Commands follow the DDR2 truth table
// R19 - Controller releases data lines during reads
`timescale 1ns/1ps
`default_nettype none

module ddrpi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wrPtr;
  logic [PW:0]      rdPtr;
  wire logic        pushOk;
  wire logic        popOk;

  assign inReady  = (wrPtr - rdPtr) != FULL;
  assign outValid = wrPtr != rdPtr;
  assign outData  = store[rdPtr[PW-1:0]];
  assign pushOk   = inValid & inReady;
  assign popOk    = outValid & outReady;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (pushOk) wrPtr <= wrPtr + 1'b1;
      if (popOk) rdPtr <= rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (pushOk) store[wrPtr[PW-1:0]] <= inData;
  end
endmodule // ddrpi_fifo

module ddrpi_device (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  // Differential memory clock
  input  wire logic                        memClk,
  input  wire logic                        memClkN,
  // Command, address, clock enable, termination
  input  wire ddrpi_pkg::ddrpi_ctl_t       ctlPins,
  // Data lanes
  input  wire logic [ddrpi_pkg::DQ_W-1:0]  dqIn,
  output logic [ddrpi_pkg::DQ_W-1:0]       dqOut,
  output logic                             dqOe,
  input  wire logic [ddrpi_pkg::LANES-1:0] dmIn,
  // Strobes
  input  wire logic [ddrpi_pkg::LANES-1:0] dqsIn,
  output logic [ddrpi_pkg::LANES-1:0]      dqsOut,
  output logic                             dqsOe,
  output logic [ddrpi_pkg::LANES-1:0]      dqsNOut,
  output logic                             dqsNOe,
  // Status
  output logic                             odtOn,
  output logic                             clocksActive,
  output logic                             writeDropped
);
  import ddrpi_pkg::*;

  // Input synchronisers
  logic              clkM, clkS, clkNM, clkNS, hiPrev;
  ddrpi_ctl_t        ctlM, ctlS;
  logic [DQ_W-1:0]   dqM, dqS;
  logic [LANES-1:0]  dmM, dmS, dqsM, dqsS, dqsPrev;

  // Mode and bank state
  logic              bl8, dqsNDis;
  logic [FLD_W-1:0]  clLat, alLat;
  logic [BANKS-1:0]  bankOpen;
  logic [ROW_W-1:0]  openRow [BANKS];
  logic [DQ_W-1:0]   mem [MEM_WORDS];

  // Burst state
  ddrpi_phase_t      rdPh, wrPh;
  logic [CNT_W-1:0]  rdWait, rdBeat, wrWait;
  logic [MEM_AW-1:0] rdBase, wrBase;
  logic [LANES-1:0]  laneDone, drop, drainFire;
  ddrpi_beat_t       drainBeat [LANES];

  function automatic logic [MEM_AW-1:0] beatAddr(input logic [MEM_AW-1:0] base,
                                                input logic [CNT_W-1:0]  beat,
                                                input logic              wrap8);
    logic [MEM_AW-1:0] a;
    a = base;
    if (wrap8) a[WRAP8_W-1:0] = base[WRAP8_W-1:0] + beat[WRAP8_W-1:0];
    else a[WRAP4_W-1:0] = base[WRAP4_W-1:0] + beat[WRAP4_W-1:0];
    return a;
  endfunction

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {clkM, clkS, clkNM, clkNS, hiPrev} <= '0;
      ctlM <= '1;
      ctlS <= '1;
      {dqM, dqS} <= '0;
      {dmM, dmS, dqsM, dqsS, dqsPrev} <= '0;
    end else begin
      {clkM, clkNM, ctlM, dqM, dmM, dqsM} <= {memClk, memClkN, ctlPins, dqIn, dmIn, dqsIn};
      {clkS, clkNS, ctlS, dqS, dmS, dqsS} <= {clkM, clkNM, ctlM, dqM, dmM, dqsM};
      hiPrev  <= clkS & ~clkNS;
      dqsPrev <= dqsS;
    end
  end

  // Crossing detection and command decode
  wire logic             hi       = clkS & ~clkNS;
  wire logic             riseEdge = hi & ~hiPrev;   // [R13]
  wire logic             anyEdge  = hi ^ hiPrev;    // [R14]
  wire logic             riseTick = riseEdge & ctlS.cke;   // [R15]
  wire logic             selected = riseTick & ~ctlS.csN;  // [R10]
  wire ddrpi_cmd_t       cmd      = ddrpi_cmd_t'({ctlS.rasN, ctlS.casN, ctlS.weN}); // [R11] [R18]
  wire logic             hitOpen  = bankOpen[ctlS.ba];     // [R5]
  wire logic             isAct    = selected & (cmd == CMD_ACT);
  wire logic             isPre    = selected & (cmd == CMD_PRE);
  wire logic             isMrs    = selected & (cmd == CMD_MRS);
  wire logic             isRd     = selected & (cmd == CMD_RD) & hitOpen;
  wire logic             isWr     = selected & (cmd == CMD_WR) & hitOpen;
  wire logic             autoPre  = ctlS.addr[AP_BIT];     // [R3]
  wire logic [CNT_W-1:0] rl       = CNT_W'(alLat) + CNT_W'(clLat); // [R17]
  wire logic [CNT_W-1:0] wl       = rl - CNT_ONE;          // [R17]
  wire logic [CNT_W-1:0] blLen    = bl8 ? BL8 : BL4;       // [R16]
  // Storage keeps only a slice of each row and column, so the model stays small
  wire logic [MEM_AW-1:0] colBase =
    {ctlS.ba, openRow[ctlS.ba][ROWSEL_W-1:0], ctlS.addr[COLSEL_W-1:0]}; // [R2]

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bl8     <= 1'b0;
      clLat   <= CL_RST;
      alLat   <= AL_RST;
      dqsNDis <= 1'b0;
    end else if (isMrs && ctlS.ba == BA_MR) begin
      if (ctlS.addr[BL_LSB +: FLD_W] == BL_CODE8) bl8 <= 1'b1;       // [R16]
      else if (ctlS.addr[BL_LSB +: FLD_W] == BL_CODE4) bl8 <= 1'b0;
      clLat <= ctlS.addr[CL_LSB +: FLD_W];
    end else if (isMrs && ctlS.ba == BA_EMR1) begin
      alLat   <= ctlS.addr[AL_LSB +: FLD_W];
      dqsNDis <= ctlS.addr[DQSN_BIT];                                  // [R9]
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      odtOn        <= 1'b0;
      clocksActive <= 1'b0;
    end else if (riseEdge) begin
      odtOn        <= ctlS.odt;  // [R6]
      clocksActive <= ctlS.cke;  // [R15]
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bankOpen <= '0;
      for (int b = 0; b < BANKS; b++) openRow[b] <= '0;
    end else begin
      if (isAct) begin
        bankOpen[ctlS.ba] <= 1'b1;
        openRow[ctlS.ba]  <= ctlS.addr[ROW_W-1:0]; // [R1] [R4]
      end
      if (isPre && autoPre) bankOpen <= '0;
      else if (isPre) bankOpen[ctlS.ba] <= 1'b0;
      if ((isRd | isWr) && autoPre) bankOpen[ctlS.ba] <= 1'b0; // [R3]
    end
  end

  // Read burst; the array is single ported, so writes drain only between read bursts
  wire logic [CNT_W-1:0] rdIdx  = (rdPh == PH_BURST) ? rdBeat : '0;
  wire logic [DQ_W-1:0]  rdWord = mem[beatAddr(rdBase, rdIdx, bl8)];
  wire logic             rdGo   = (rdPh == PH_WAIT) & riseTick & (rdWait == CNT_ONE);
  wire logic             rdLast = (rdPh == PH_BURST) & anyEdge & (rdBeat == blLen);
  wire logic             rdStep = (rdPh == PH_BURST) & anyEdge & (rdBeat != blLen);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdPh   <= PH_IDLE;
      rdWait <= '0;
      rdBase <= '0;
    end else begin
      case (rdPh)
        PH_IDLE: if (isRd) begin
          rdPh   <= PH_WAIT;
          rdWait <= rl;      // [R17]
          rdBase <= colBase;
        end
        PH_WAIT: if (rdGo) rdPh <= PH_BURST;
          else if (riseTick) rdWait <= rdWait - CNT_ONE;
        PH_BURST: if (rdLast) rdPh <= PH_IDLE;
        default: rdPh <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdBeat <= '0;
      dqOe   <= 1'b0;
      dqOut  <= '0;
      dqsOut <= '0;
    end else if (rdGo | rdStep) begin
      rdBeat <= rdIdx + CNT_ONE;            // [R16]
      dqOe   <= 1'b1;
      dqOut  <= rdWord;                     // [R14]
      dqsOut <= {LANES{~rdIdx[0]}};         // [R7] [R8]
    end else if (rdLast) begin
      dqOe   <= 1'b0;
      dqsOut <= '0;
    end
  end

  assign dqsOe   = dqOe;
  assign dqsNOut = ~dqsOut;
  assign dqsNOe  = dqOe & ~dqsNDis; // [R9]

  // Write burst window
  wire logic wrStart  = (wrPh == PH_WAIT) & riseTick & (wrWait == CNT_ONE);
  wire logic wrWindow = wrStart | (wrPh == PH_BURST);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPh   <= PH_IDLE;
      wrWait <= '0;
      wrBase <= '0;
    end else begin
      case (wrPh)
        PH_IDLE: if (isWr) begin
          wrPh   <= PH_WAIT;
          wrWait <= wl;      // [R17]
          wrBase <= colBase;
        end
        PH_WAIT: if (wrStart) wrPh <= PH_BURST;
          else if (riseTick) wrWait <= wrWait - CNT_ONE;
        PH_BURST: if (&laneDone) wrPh <= PH_IDLE;
        default: wrPh <= PH_IDLE;
      endcase
    end
  end

  // Drain stalls during a read burst, so the lane buffers really fill
  wire logic drainReady = rdPh != PH_BURST;

  for (genvar l = 0; l < LANES; l++) begin : gLane
    logic [CNT_W-1:0] cnt;
    logic             fillReady, drainValid;
    wire logic        take = wrWindow & (dqsS[l] ^ dqsPrev[l]) & (cnt != blLen); // [R7] [R8]
    wire logic        push = take & ~dmS[l];                                      // [R12]
    wire ddrpi_beat_t beat = '{addr: beatAddr(wrBase, cnt, bl8),
                               data: dqS[l*LANE_W +: LANE_W]};

    assign laneDone[l]  = cnt == blLen; // [R16]
    assign drop[l]      = push & ~fillReady;
    assign drainFire[l] = drainValid & drainReady;

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) cnt <= '0;
      else if (isWr && wrPh == PH_IDLE) cnt <= '0;
      else if (take) cnt <= cnt + CNT_ONE;
    end

    ddrpi_fifo #(
      .WIDTH ($bits(ddrpi_beat_t)),
      .DEPTH (FIFO_DEPTH)
    ) uFifo (
      .clk      (core_clk),
      .resetn   (resetn),
      .inValid  (push),
      .inReady  (fillReady),
      .inData   (beat),
      .outValid (drainValid),
      .outReady (drainReady),
      .outData  (drainBeat[l])
    );

    AST_MASKED_NOT_PUSHED: assert property (@(posedge core_clk) disable iff (!resetn) // [R12]
                                            take && dmS[l] |-> !push)
      else $error("masked beat entered the write buffer");
  end

  always_ff @(posedge core_clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (drainFire[l]) mem[drainBeat[l].addr][l*LANE_W +: LANE_W] <= drainBeat[l].data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) writeDropped <= 1'b0;
    else writeDropped <= |drop;
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic [CNT_W-1:0] rlCount, oeEdges;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rlCount <= '0;
      oeEdges <= '0;
    end else begin
      if (rdPh == PH_IDLE) rlCount <= '0;
      else if (rdPh == PH_WAIT && riseTick) rlCount <= rlCount + CNT_ONE;
      if (!dqOe) oeEdges <= '0;
      else if (anyEdge) oeEdges <= oeEdges + CNT_ONE;
    end
  end

  sequence sRdAccept;
    isRd && autoPre;
  endsequence
  sequence sBurstStart;
    $rose(rdPh == PH_BURST);
  endsequence

  AST_ODT_REGISTERED: assert property (riseEdge |=> odtOn == $past(ctlS.odt)) // [R6]
    else $error("termination does not follow registered ODT");
  AST_CS_MASKS: assert property (riseEdge && ctlS.csN && rdPh == PH_IDLE |=> rdPh == PH_IDLE) // [R10]
    else $error("command accepted with chip select high");
  AST_CKE_FREEZE: assert property (riseEdge && !ctlS.cke && rdPh == PH_WAIT |=> $stable(rdWait)) // [R15]
    else $error("latency advanced with clock enable low");
  AST_READ_LATENCY: assert property (sBurstStart |-> rlCount == rl) // [R17]
    else $error("read burst did not start after AL plus CL clocks");
  AST_BURST_BEATS: assert property ($fell(dqOe) |-> oeEdges == blLen) // [R16]
    else $error("read burst length differs from programmed length");
  AST_STROBE_ON_CROSSING: assert property (dqOe && $past(dqOe) && $changed(dqsOut) |-> $past(anyEdge)) // [R14]
    else $error("read strobe moved away from a clock crossing");
  AST_DIFF_STROBE: assert property (dqsNOe |-> !dqsNDis && dqsNOut == ~dqsOut) // [R9]
    else $error("complementary strobe driven outside differential mode");
  AST_AUTO_PRECHARGE: assert property (sRdAccept |=> !bankOpen[$past(ctlS.ba)]) // [R3]
    else $error("auto-precharge left the bank open");
  AST_ACTIVATE_ROW: assert property (isAct |=> bankOpen[$past(ctlS.ba)] ##0
                                    openRow[$past(ctlS.ba)] == $past(ctlS.addr[ROW_W-1:0])) // [R1]
    else $error("activate did not latch the row");
  AST_READ_FIRST_BEAT: assert property (sBurstStart |-> dqOe && dqsOut == '1) // [R7]
    else $error("first read beat not launched with strobe high");
endmodule // ddrpi_device

`default_nettype wire

// ### verif/ddrpi_ctrl_model.sv
// Memory controller model: free-running memory clock, commands and write bursts.
// Assumes the device oversamples every pin with its own core clock.
`timescale 1ns/1ps
`default_nettype none
module ddrpi_ctrl_model (
  // Memory clock pair
  output logic                             memClk,
  output logic                             memClkN,
  // Command, address and data pins
  output ddrpi_pkg::ddrpi_ctl_t            ctlPins,
  output logic [ddrpi_pkg::DQ_W-1:0]       dqIn,
  output logic [ddrpi_pkg::LANES-1:0]      dmIn,
  output logic [ddrpi_pkg::LANES-1:0]      dqsIn,
  // Count of rising crossings
  output int                               riseCnt
);
  import ddrpi_pkg::*;

  initial begin
    memClk = 1'b0;
    riseCnt = 0;
    ctlPins = {4'hF, 17'h00000};
    dqIn = 16'h0000;
    dmIn = 2'h0;
    dqsIn = 2'h0;
    // Phase offset keeps memory edges away from core edges
    #13;
    forever #160 memClk = ~memClk;
  end

  assign memClkN = ~memClk;

  always @(posedge memClk) riseCnt <= riseCnt + 1;

  // Pins change at the falling crossing, centred on the sampling rise
  task automatic cmd(input logic [2:0] c, input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a,
                     input logic cs, input logic ck, input logic od, output int r0);
    @(negedge memClk);
    ctlPins <= {cs, c, ck, od, ba, a};
    r0 = riseCnt + 1;
    @(negedge memClk);
    ctlPins <= {1'b1, CMD_NOP, ck, od, ba, ~a};
  endtask

  // Beats are slower than the memory clock allows; lag delays the first strobe edge
  task automatic wburst(input int r0, input int wl, input int bl, input int lag,
                        input logic [DQ_W-1:0] d [8], input logic [LANES-1:0] m [8]);
    repeat (r0 + wl - riseCnt) @(posedge memClk);
    #(lag * 40);
    for (int k = 0; k < bl; k++) begin
      dqIn <= d[k];
      dmIn <= m[k];
      #160;
      dqsIn <= {LANES{~k[0]}};
      #160;
    end
    // Released lines do not keep the last beat
    dqIn <= ~d[bl-1];
    dmIn <= ~m[bl-1];
  endtask
endmodule // ddrpi_ctrl_model
`default_nettype wire

// ### verif/ddrpi_device_test.sv
// Self-checking bench for the pin-side device and its lane buffers.
// Assumes the controller model owns every memory pin; core clock 25 MHz.
`timescale 1ns/1ps
`default_nettype none
module ddrpi_device_test;
  import ddrpi_pkg::*;
  localparam int WAIT_LIM = 160;
  logic                core_clk;
  logic                resetn;
  logic                memClk;
  logic                memClkN;
  ddrpi_ctl_t          ctlPins;
  logic [DQ_W-1:0]     dqIn;
  logic [DQ_W-1:0]     dqOut;
  logic                dqOe;
  logic [LANES-1:0]    dmIn;
  logic [LANES-1:0]    dqsIn;
  logic [LANES-1:0]    dqsOut;
  logic                dqsOe;
  logic [LANES-1:0]    dqsNOut;
  logic                dqsNOe;
  logic                odtOn;
  logic                clocksActive;
  logic                writeDropped;
  int                  riseCnt;
  int                  heldBeats = 0;
  int                  dropCnt = 0;
  logic [LANES-1:0]    prevIn;
  int                  err_count = 0;
  int                  tests_run = 0;
  int                  nBeat = 0;
  int                  firstRise;
  int                  rx;
  int                  rl = 3;
  int                  bl = 4;
  logic [31:0]         seed = 32'hE60FE091;
  logic                csV = 1'b0;
  logic                ckV = 1'b1;
  logic                odV = 1'b0;
  logic                diff = 1'b1;
  logic                nOeSeen;
  logic                pinFault = 1'b0;
  logic                prevOe;
  logic [LANES-1:0]    prevDqs;
  logic [DQ_W-1:0]     refMem [MEM_WORDS];
  logic [DQ_W-1:0]     got [16];
  logic [LANES-1:0]    gotDqs [16];
  logic [ROW_W-1:0]    rows [BANKS];

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  ddrpi_ctrl_model ctrl (.memClk(memClk), .memClkN(memClkN), .ctlPins(ctlPins), .dqIn(dqIn),
    .dmIn(dmIn), .dqsIn(dqsIn), .riseCnt(riseCnt));
  ddrpi_device dut (.core_clk(core_clk), .resetn(resetn), .memClk(memClk), .memClkN(memClkN),
    .ctlPins(ctlPins), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .dmIn(dmIn), .dqsIn(dqsIn),
    .dqsOut(dqsOut), .dqsOe(dqsOe), .dqsNOut(dqsNOut), .dqsNOe(dqsNOe), .odtOn(odtOn),
    .clocksActive(clocksActive), .writeDropped(writeDropped));

  // A beat starts when the output enable rises or the strobe changes
  always @(posedge core_clk) begin
    prevOe <= dqOe;
    prevDqs <= dqsOut;
    prevIn <= dqsIn;
    if (dqOe === 1'b1 && dqsIn !== prevIn) heldBeats = heldBeats + 1;
    if (writeDropped === 1'b1) dropCnt = dropCnt + 1;
    if (dqsNOe === 1'b1) nOeSeen <= 1'b1;
    if (dqsOe !== dqOe || writeDropped === 1'b1) pinFault <= 1'b1;
    if (dqOe === 1'b1 && (prevOe !== 1'b1 || dqsOut !== prevDqs) && nBeat < 16) begin
      if (prevOe !== 1'b1) firstRise = riseCnt;
      got[nBeat] = dqOut;
      gotDqs[nBeat] = dqsOut;
      nBeat = nBeat + 1;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Storage slot of beat k: column wraps within the burst
  function automatic logic [MEM_AW-1:0] slot(input logic [1:0] b, input logic [8:0] c, input int k);
    logic [3:0] m;
    logic [3:0] w;
    m = 4'(bl - 1);
    w = (c[3:0] & ~m) | ((c[3:0] + 4'(k)) & m);
    return {b, rows[b][1:0], w};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                       output int r0);
    ctrl.cmd(c, b, a, csV, ckV, odV, r0);
  endtask

  task automatic do_write(input logic [1:0] b, input logic [8:0] c, input logic msk);
    logic [DQ_W-1:0] d [8];
    logic [LANES-1:0] m [8];
    int r0;
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      d[k] = seed[15:0];
      m[k] = msk ? seed[17:16] : 2'h0;
    end
    issue(CMD_WR, b, {4'h8, c}, r0);
    ctrl.wburst(r0, rl - 1, bl, int'(seed[19:18]), d, m);
    for (int k = 0; k < bl; k++) begin
      for (int l = 0; l < LANES; l++) begin
        if (!m[k][l]) refMem[slot(b, c, k)][l*8 +: 8] = d[k][l*8 +: 8];
      end
    end
  endtask

  task automatic do_read(input logic [1:0] b, input logic [8:0] c, input logic ap);
    int r0;
    int w;
    nBeat = 0;
    nOeSeen = 1'b0;
    issue(CMD_RD, b, {2'h2, ap, 1'b0, c}, r0);
    for (w = 0; w < WAIT_LIM && !(nBeat == bl && dqOe === 1'b0); w++) begin
      @(posedge core_clk);
    end
    if (w == WAIT_LIM) begin
      err_count++;
      $display("[FAIL] read beats expected %0d seen %0d", bl, nBeat);
      complete_run;
    end
    check("read_latency", firstRise - r0, rl);
    check("dqs_n_enable", nOeSeen, diff);
    for (int k = 0; k < bl; k++) begin
      check("read_data", got[k], refMem[slot(b, c, k)]);
      check("read_strobe", gotDqs[k], {2{~k[0]}});
    end
  endtask

  task automatic expect_idle(input logic [1:0] b);
    nBeat = 0;
    issue(CMD_RD, b, 13'h0000, rx);
    repeat (rl + bl) @(posedge memClk);
    check("ignored_read", nBeat, 0);
  endtask

  task automatic open_banks;
    for (int b = 0; b < BANKS; b++) begin
      seed = lfsr(seed);
      rows[b] = seed[11:0];
      issue(CMD_ACT, b[1:0], {1'b1, rows[b]}, rx);
    end
  endtask

  task automatic traffic(input int n);
    logic [1:0] b;
    logic [8:0] c;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      b = seed[1:0];
      c = seed[10:2];
      do_write(b, c, 1'b0);
      if (i[0]) do_write(b, c, 1'b1);
      seed = lfsr(seed);
      do_read(b, c ^ (9'(bl - 1) & seed[8:0]), 1'b0);
    end
    $display("traffic of %0d bursts done", n);
  endtask

  // Write beats that land during a read burst must wait in the lane buffers
  task automatic overlap(input logic [1:0] bw, input logic [1:0] br);
    logic [8:0] c;
    seed = lfsr(seed);
    c = seed[8:0];
    do_write(br, c, 1'b0);
    heldBeats = 0;
    dropCnt = 0;
    fork
      do_write(bw, c, 1'b0);
      begin
        // Read goes out two command slots after the write, never on the same edge
        repeat (2) @(negedge memClk);
        do_read(br, c, 1'b0);
      end
    join
    check("buffer_overlap", heldBeats != 0, 1'b1);
    check("buffer_beats", nBeat, bl);
    do_read(bw, c, 1'b0);
    check("buffer_drop", dropCnt, 0);
    check("buffer_idle", dqOe, 1'b0);
    $display("buffered write during read done");
  endtask

  initial begin
    #4000000;
    err_count++;
    $display("[FAIL] run length expected finish seen timeout");
    complete_run;
  end

  initial begin
    resetn = 1'b0;
    repeat (3) @(posedge core_clk);
    check("reset_outputs", {dqOe, dqsOe, odtOn, clocksActive}, 4'h0);
    check("reset_dqs_n", dqsNOut, 2'h3);
    resetn <= 1'b1;
    odV = 1'b1;
    issue(CMD_NOP, 2'h0, 13'h0000, rx);
    repeat (2) @(posedge core_clk);
    check("odt_on", {odtOn, clocksActive}, 2'h3);
    odV = 1'b0;
    issue(CMD_NOP, 2'h0, 13'h0000, rx);
    repeat (2) @(posedge core_clk);
    check("odt_off", odtOn, 1'b0);
    $display("pin registration done");
    open_banks();
    traffic(6);
    overlap(2'h1, 2'h2);
    // Deselected, reserved and refresh codes leave the array alone
    csV = 1'b1;
    expect_idle(2'h0);
    csV = 1'b0;
    issue(CMD_RSV, 2'h0, 13'h0000, rx);
    issue(CMD_REF, 2'h0, 13'h0000, rx);
    do_write(2'h0, 9'h000, 1'b0);
    do_read(2'h0, 9'h001, 1'b1);
    expect_idle(2'h0);
    issue(CMD_ACT, 2'h0, {1'b0, rows[0]}, rx);
    ckV = 1'b0;
    issue(CMD_NOP, 2'h0, 13'h0000, rx);
    repeat (2) @(posedge core_clk);
    check("clock_enable_low", clocksActive, 1'b0);
    expect_idle(2'h1);
    ckV = 1'b1;
    issue(CMD_PRE, 2'h0, 13'h0400, rx);
    expect_idle(2'h2);
    $display("ignored commands done");
    // Burst of eight, additive latency one, single-ended strobe
    issue(CMD_MRS, BA_MR, 13'h0033, rx);
    issue(CMD_MRS, BA_EMR1, 13'h0408, rx);
    bl = 8;
    rl = 4;
    diff = 1'b0;
    open_banks();
    traffic(4);
    overlap(2'h1, 2'h2);
    check("pin_fault", pinFault, 1'b0);
    complete_run;
  end
endmodule // ddrpi_device_test
`default_nettype wire
